// >>> core/route_cfg_pkg.sv
// constants for the block output routing and clock resync register bank
package route_cfg_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OUT_CFG_OFFSET    = 8'h00;
  localparam logic [7:0] FUNC_CFG_OFFSET   = 8'h04;
  localparam logic [7:0] CLK_SEL_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET     = 8'h0C;

  // reset values
  localparam logic [7:0] OUT_CFG_RESET     = 8'h00;
  localparam logic [3:0] FUNC_CFG_RESET    = 4'h0;
  localparam logic [3:0] CLK_SEL_RESET     = 4'h0;

  // output config fields
  localparam int RESYNC_MSB                = 7;
  localparam int RESYNC_LSB                = 6;
  localparam int SEC_EN_BIT                = 5;
  localparam int SEC_SEL_MSB               = 4;
  localparam int SEC_SEL_LSB               = 3;
  localparam int MAIN_EN_BIT               = 2;
  localparam int MAIN_SEL_MSB              = 1;
  localparam int MAIN_SEL_LSB              = 0;

  // function config fields
  localparam int FUNC_MSB                  = 2;
  localparam int FUNC_LSB                  = 0;
  localparam int MODE0_BIT                 = 3;

  // resync codes
  typedef enum logic [1:0] {
    RESYNC_BYPASS = 2'b00,
    RESYNC_TO_24M = 2'b01,
    RESYNC_TO_48M = 2'b10,
    DIRECT_24M    = 2'b11
  } resync_type;

  // block functions
  typedef enum logic [2:0] {
    FN_TIMER    = 3'b000,
    FN_COUNTER  = 3'b001,
    FN_CRC_PRBS = 3'b010,
    FN_PWM_DUAL = 3'b011,
    FN_DEADBAND = 3'b100,
    FN_UART     = 3'b101,
    FN_SPI      = 3'b110,
    FN_DELTA_SG = 3'b111
  } func_type;

  // event input bit positions
  localparam int EV_TERM_COUNT             = 0;
  localparam int EV_LAST_SHOT              = 1;
  localparam int EV_COMPARE                = 2;
  localparam int EV_CAPTURE                = 3;
  localparam int EV_KILL                   = 4;
  localparam int EV_PHASE1                 = 5;
  localparam int EV_DS                     = 6;
  localparam int EV_TX_EMPTY               = 7;
  localparam int EV_XFER_DONE              = 8;
  localparam int EV_RX_FULL                = 9;
  localparam int EV_DENSITY                = 10;
  localparam int EV_WIDTH                  = 11;

  // interrupt source masks per function
  localparam logic [10:0] IRQ_MASK_TIMER   = 11'h01F;
  localparam logic [10:0] IRQ_MASK_COUNTER = 11'h017;
  localparam logic [10:0] IRQ_MASK_PHASE   = 11'h030;
  localparam logic [10:0] IRQ_MASK_CRC     = 11'h054;
  localparam logic [10:0] IRQ_MASK_SPI     = 11'h180;
  localparam logic [10:0] IRQ_MASK_UART_TX = 11'h180;
  localparam logic [10:0] IRQ_MASK_UART_RX = 11'h200;
  localparam logic [10:0] IRQ_MASK_DSM     = 11'h410;
endpackage : route_cfg_pkg

// >>> core/sync_two_flop.sv
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ns
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  initial begin
    if (WIDTH < 1) $error("sync_two_flop: WIDTH must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule : sync_two_flop

// >>> core/clock_resync.sv
// block clock selection and resynchronisation to a system clock
`timescale 1ns/1ns
module clock_resync (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire route_cfg_pkg::resync_type mode,
  input  wire logic                     selected_clock,
  input  wire logic                     system_clock_24m,
  input  wire logic                     system_clock_48m,
  output logic                          block_clock
);
  logic sys24_d_r;
  logic sys48_d_r;
  logic held_r;
  logic held_nxt;
  logic out_r;
  logic out_nxt;
  logic rise24;
  logic rise48;

  assign rise24 = system_clock_24m & ~sys24_d_r;
  assign rise48 = system_clock_48m & ~sys48_d_r;

  always_comb begin
    held_nxt = held_r;
    out_nxt  = out_r;
    case (mode)
      route_cfg_pkg::RESYNC_BYPASS: begin
        out_nxt = selected_clock;
      end
      route_cfg_pkg::RESYNC_TO_24M: begin
        if (rise24) begin
          held_nxt = selected_clock;
        end
        out_nxt = held_r;
      end
      route_cfg_pkg::RESYNC_TO_48M: begin
        if (rise48) begin
          held_nxt = selected_clock;
        end
        out_nxt = held_r;
      end
      route_cfg_pkg::DIRECT_24M: begin
        out_nxt = system_clock_24m;
      end
      default: begin
        out_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys24_d_r <= 1'b0;
      sys48_d_r <= 1'b0;
      held_r    <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      sys24_d_r <= system_clock_24m;
      sys48_d_r <= system_clock_48m;
      held_r    <= held_nxt;
      out_r     <= out_nxt;
    end
  end

  assign block_clock = out_r;
endmodule : clock_resync

// >>> core/block_output_routing.sv
// apb register bank steering function outputs onto row outputs and resyncing the block clock
//
// What this block does
// - spi target, drive enable clear: route field picks one of four row inputs as select
// - spi target, drive enable set: target select equals route field bit 0
// - spi target function always keeps secondary row output drivers off
// - main and secondary outputs come from the running function's own outputs
// - interrupt source is the or of events that the function defines
// - uart secondary clock toggles only during data bits of a byte
// - bits 7:6 enable resync of the clock after the 16-to-1 mux
// - code 00 bypass, 01 resync to 24 MHz, 10 resync to 48 MHz
// - code 11 clocks block straight from 24 MHz, ignoring the mux
// - outside spi target, bit 5 drives secondary output onto the chosen row
// - bits 4:3 pick the secondary row output, or the select source row input
// - bit 2 drives the main output onto the chosen row output
// - bits 1:0 choose which row output carries the main output
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
module block_output_routing #(
  parameter int ROWS        = 4,
  parameter int CLK_SOURCES = 16
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      main_function_out,
  input  wire logic                      secondary_function_out,
  input  wire logic                      uart_data_bits_active,
  input  wire logic [route_cfg_pkg::EV_WIDTH-1:0] function_events,
  input  wire logic [ROWS-1:0]           row_in,
  input  wire logic [CLK_SOURCES-1:0]    clock_sources,
  input  wire logic                      system_clock_24m,
  input  wire logic                      system_clock_48m,
  output logic      [ROWS-1:0]           row_out,
  output logic      [ROWS-1:0]           row_out_en,
  output logic                           target_select,
  output logic                           block_clock,
  output logic                           interrupt_source
);
  initial begin
    if (ROWS != 4) $error("block_output_routing: two-bit select fields serve exactly four rows");
    if (CLK_SOURCES != 16) $error("block_output_routing: the clock mux is 16-to-1");
  end

  // register state
  logic [7:0]  out_cfg_r;
  logic [7:0]  out_cfg_nxt;
  logic [3:0]  func_cfg_r;
  logic [3:0]  func_cfg_nxt;
  logic [3:0]  clk_sel_r;
  logic [3:0]  clk_sel_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  // routed outputs
  logic [ROWS-1:0] row_out_r;
  logic [ROWS-1:0] row_out_nxt;
  logic [ROWS-1:0] row_en_r;
  logic [ROWS-1:0] row_en_nxt;
  logic            target_sel_r;
  logic            target_sel_nxt;
  logic            irq_r;
  logic            irq_nxt;

  // synchronised pins
  logic [ROWS-1:0]        row_in_s;
  logic [CLK_SOURCES-1:0] clk_src_s;
  logic                   sys24_s;
  logic                   sys48_s;

  // decoded configuration
  route_cfg_pkg::func_type   func;
  route_cfg_pkg::resync_type resync_mode;
  logic                      mode0;
  logic                      spi_target;
  logic                      uart_fn;
  logic                      sec_en;
  logic [1:0]                sec_sel;
  logic                      main_en;
  logic [1:0]                main_sel;
  logic                      secondary_gated;
  logic [route_cfg_pkg::EV_WIDTH-1:0] irq_mask;
  logic                      selected_clock;
  logic                      block_clock_w;

  logic access_phase;
  logic setup_phase;
  logic mapped;

  sync_two_flop #(
    .WIDTH (ROWS + CLK_SOURCES + 2)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({row_in, clock_sources, system_clock_24m, system_clock_48m}),
    .sync_out ({row_in_s, clk_src_s, sys24_s, sys48_s})
  );

  assign func        = route_cfg_pkg::func_type'(func_cfg_r[route_cfg_pkg::FUNC_MSB:route_cfg_pkg::FUNC_LSB]);
  assign mode0       = func_cfg_r[route_cfg_pkg::MODE0_BIT];
  assign resync_mode = route_cfg_pkg::resync_type'(out_cfg_r[route_cfg_pkg::RESYNC_MSB:route_cfg_pkg::RESYNC_LSB]);
  assign sec_en      = out_cfg_r[route_cfg_pkg::SEC_EN_BIT];
  assign sec_sel     = out_cfg_r[route_cfg_pkg::SEC_SEL_MSB:route_cfg_pkg::SEC_SEL_LSB];
  assign main_en     = out_cfg_r[route_cfg_pkg::MAIN_EN_BIT];
  assign main_sel    = out_cfg_r[route_cfg_pkg::MAIN_SEL_MSB:route_cfg_pkg::MAIN_SEL_LSB];
  assign spi_target  = (func == route_cfg_pkg::FN_SPI) && mode0;
  assign uart_fn     = (func == route_cfg_pkg::FN_UART);

  // the mux ahead of resync; code 11 ignores it inside clock_resync
  assign selected_clock = clk_src_s[clk_sel_r];

  clock_resync u_clock_resync (
    .pclk             (pclk),
    .presetn          (presetn),
    .mode             (resync_mode),
    .selected_clock   (selected_clock),
    .system_clock_24m (sys24_s),
    .system_clock_48m (sys48_s),
    .block_clock      (block_clock_w)
  );

  // apb slave: no wait state, yet every answer comes from a flop
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable && pready_r;
  assign mapped = (paddr == route_cfg_pkg::OUT_CFG_OFFSET) || (paddr == route_cfg_pkg::FUNC_CFG_OFFSET) ||
                  (paddr == route_cfg_pkg::CLK_SEL_OFFSET) || (paddr == route_cfg_pkg::STATUS_OFFSET);

  always_comb begin
    out_cfg_nxt  = out_cfg_r;
    func_cfg_nxt = func_cfg_r;
    clk_sel_nxt  = clk_sel_r;
    prdata_nxt   = prdata_r;
    pready_nxt   = setup_phase;
    pslverr_nxt  = 1'b0;
    if (setup_phase) begin
      pslverr_nxt = !mapped;
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          route_cfg_pkg::OUT_CFG_OFFSET:  prdata_nxt = {24'h00_0000, out_cfg_r};
          route_cfg_pkg::FUNC_CFG_OFFSET: prdata_nxt = {28'h000_0000, func_cfg_r};
          route_cfg_pkg::CLK_SEL_OFFSET:  prdata_nxt = {28'h000_0000, clk_sel_r};
          route_cfg_pkg::STATUS_OFFSET:   prdata_nxt = {20'h0_0000, row_en_r, row_out_r,
                                                        irq_r, block_clock_w, target_sel_r, spi_target};
          default:                        prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (access_phase && pwrite) begin
      case (paddr)
        route_cfg_pkg::OUT_CFG_OFFSET:  out_cfg_nxt  = pwdata[7:0];
        route_cfg_pkg::FUNC_CFG_OFFSET: func_cfg_nxt = pwdata[3:0];
        route_cfg_pkg::CLK_SEL_OFFSET:  clk_sel_nxt  = pwdata[3:0];
        default: begin
          out_cfg_nxt = out_cfg_r;
        end
      endcase
    end
  end

  // uart secondary is a clock only while data bits move
  always_comb begin
    secondary_gated = secondary_function_out;
    if (uart_fn) begin
      secondary_gated = secondary_function_out & uart_data_bits_active;
    end
  end

  // row output drive: undriven rows stay free for other sources
  always_comb begin
    row_out_nxt = '0;
    row_en_nxt  = '0;
    for (int i = 0; i < ROWS; i++) begin
      if (main_en && (main_sel == 2'(i))) begin
        row_en_nxt[i]  = 1'b1;
        row_out_nxt[i] = main_function_out;
      end
      // secondary drivers forced off in the spi target function
      if (!spi_target && sec_en && (sec_sel == 2'(i))) begin
        row_en_nxt[i]  = 1'b1;
        // main wins if both pick the same row, avoiding a contended driver
        if (!(main_en && (main_sel == 2'(i)))) begin
          row_out_nxt[i] = secondary_gated;
        end
      end
    end
    // rows without an enable keep en low and data low
  end

  // spi target select source
  always_comb begin
    target_sel_nxt = 1'b0;
    if (spi_target) begin
      if (sec_en) begin
        target_sel_nxt = sec_sel[0];
      end else begin
        target_sel_nxt = row_in_s[sec_sel];
      end
    end
  end

  // interrupt source per function
  always_comb begin
    case (func)
      route_cfg_pkg::FN_TIMER:    irq_mask = route_cfg_pkg::IRQ_MASK_TIMER;
      route_cfg_pkg::FN_COUNTER:  irq_mask = route_cfg_pkg::IRQ_MASK_COUNTER;
      route_cfg_pkg::FN_PWM_DUAL: irq_mask = route_cfg_pkg::IRQ_MASK_PHASE;
      route_cfg_pkg::FN_DEADBAND: irq_mask = route_cfg_pkg::IRQ_MASK_PHASE;
      route_cfg_pkg::FN_CRC_PRBS: irq_mask = route_cfg_pkg::IRQ_MASK_CRC;
      route_cfg_pkg::FN_SPI:      irq_mask = route_cfg_pkg::IRQ_MASK_SPI;
      route_cfg_pkg::FN_UART:     irq_mask = mode0 ? route_cfg_pkg::IRQ_MASK_UART_TX
                                                   : route_cfg_pkg::IRQ_MASK_UART_RX;
      route_cfg_pkg::FN_DELTA_SG: irq_mask = route_cfg_pkg::IRQ_MASK_DSM;
      default:                    irq_mask = '0;
    endcase
    irq_nxt = |(function_events & irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cfg_r    <= route_cfg_pkg::OUT_CFG_RESET;
      func_cfg_r   <= route_cfg_pkg::FUNC_CFG_RESET;
      clk_sel_r    <= route_cfg_pkg::CLK_SEL_RESET;
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
      row_out_r    <= '0;
      row_en_r     <= '0;
      target_sel_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      out_cfg_r    <= out_cfg_nxt;
      func_cfg_r   <= func_cfg_nxt;
      clk_sel_r    <= clk_sel_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
      row_out_r    <= row_out_nxt;
      row_en_r     <= row_en_nxt;
      target_sel_r <= target_sel_nxt;
      irq_r        <= irq_nxt;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign row_out          = row_out_r;
  assign row_out_en       = row_en_r;
  assign target_select    = target_sel_r;
  assign block_clock      = block_clock_w;
  assign interrupt_source = irq_r;
endmodule : block_output_routing

// >>> verification/route_checker_asserts.sv
// concurrent checks for the output routing register bank
`timescale 1ns/1ns
module route_checker #(
  parameter int ROWS        = 4,
  parameter int CLK_SOURCES = 16
) (
  input wire logic                                pclk,
  input wire logic                                presetn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [7:0]                          paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic                                main_function_out,
  input wire logic                                secondary_function_out,
  input wire logic                                uart_data_bits_active,
  input wire logic [route_cfg_pkg::EV_WIDTH-1:0]  function_events,
  input wire logic [ROWS-1:0]                     row_in,
  input wire logic [CLK_SOURCES-1:0]              clock_sources,
  input wire logic                                system_clock_24m,
  input wire logic                                system_clock_48m,
  input wire logic [ROWS-1:0]                     row_out,
  input wire logic [ROWS-1:0]                     row_out_en,
  input wire logic                                target_select,
  input wire logic                                block_clock,
  input wire logic                                interrupt_source
);
  logic [7:0]      cfg_r, cfg_nxt;
  logic [3:0]      fn_r, fn_nxt, ck_r, ck_nxt;
  logic [2:0]      age_r, age_nxt;
  logic            wr, tgt;
  logic [ROWS-1:0] en_m, en_s;
  logic [10:0]     msk;
  // shadow of the config so outputs can be tied to what software wrote
  always_comb begin
    wr = psel && penable && pready && pwrite;
    cfg_nxt = (wr && paddr == 8'h00) ? pwdata[7:0] : cfg_r;
    fn_nxt = (wr && paddr == 8'h04) ? pwdata[3:0] : fn_r;
    ck_nxt = (wr && paddr == 8'h08) ? pwdata[3:0] : ck_r;
    age_nxt = wr ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
    tgt = fn_r == 4'hE;
    en_m = cfg_r[2] ? ROWS'(1) << cfg_r[1:0] : '0;
    en_s = (cfg_r[5] && !tgt) ? ROWS'(1) << cfg_r[4:3] : '0;
    case (fn_r[2:0])
      3'h0: msk = route_cfg_pkg::IRQ_MASK_TIMER;
      3'h1: msk = route_cfg_pkg::IRQ_MASK_COUNTER;
      3'h2: msk = route_cfg_pkg::IRQ_MASK_CRC;
      3'h5: msk = fn_r[3] ? route_cfg_pkg::IRQ_MASK_UART_TX : route_cfg_pkg::IRQ_MASK_UART_RX;
      3'h6: msk = route_cfg_pkg::IRQ_MASK_SPI;
      3'h7: msk = route_cfg_pkg::IRQ_MASK_DSM;
      default: msk = route_cfg_pkg::IRQ_MASK_PHASE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h00;
      fn_r <= 4'h0;
      ck_r <= 4'h0;
      age_r <= 3'h0;
    end else begin
      cfg_r <= cfg_nxt;
      fn_r <= fn_nxt;
      ck_r <= ck_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  ready_pulse_a: assert property (setup_s |=> answer_s)
    else $error("pready is not a one cycle answer");
  slverr_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h0C))
    else $error("pslverr does not match the address map");
  en_map_a: assert property (row_out_en == $past(en_m | en_s))
    else $error("row drive enables do not follow the output config");
  data_map_a: assert property (row_out == $past((en_m & {ROWS{main_function_out}}) |
    (en_s & ~en_m & {ROWS{secondary_function_out & (fn_r[2:0] != 3'h5 || uart_data_bits_active)}})))
    else $error("row output data does not follow the routing");
  tsel_force_a: assert property (age_r >= 3'h2 && tgt && cfg_r[5] |-> target_select == cfg_r[3])
    else $error("forced target select differs from route bit 0");
  tsel_row_a: assert property (age_r >= 3'h3 && tgt && !cfg_r[5] |->
    target_select == $past(row_in[cfg_r[4:3]], 3))
    else $error("target select does not follow the chosen row input");
  irq_mask_a: assert property (age_r >= 3'h2 |-> interrupt_source == $past(|(function_events & msk)))
    else $error("interrupt source differs from the function events");
  bypass_clk_a: assert property (age_r >= 3'h3 && cfg_r[7:6] == 2'h0 |->
    block_clock == $past(clock_sources[ck_r], 3))
    else $error("bypassed block clock differs from the selected source");
  direct_clk_a: assert property (age_r >= 3'h3 && cfg_r[7:6] == 2'h3 |->
    block_clock == $past(system_clock_24m, 3))
    else $error("direct block clock differs from the 24 MHz clock");
  resync_edge_a: assert property (age_r >= 3'h6 && cfg_r[7:6] == 2'h1 && $changed(block_clock) |->
    ($past(system_clock_24m, 3) && !$past(system_clock_24m, 4)) ||
    ($past(system_clock_24m, 4) && !$past(system_clock_24m, 5)))
    else $error("resynced block clock moved off a 24 MHz rise");
endmodule : route_checker

bind block_output_routing route_checker #(.ROWS(ROWS), .CLK_SOURCES(CLK_SOURCES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .main_function_out(main_function_out), .secondary_function_out(secondary_function_out),
  .uart_data_bits_active(uart_data_bits_active), .function_events(function_events),
  .row_in(row_in), .clock_sources(clock_sources), .system_clock_24m(system_clock_24m),
  .system_clock_48m(system_clock_48m), .row_out(row_out), .row_out_en(row_out_en),
  .target_select(target_select), .block_clock(block_clock), .interrupt_source(interrupt_source));

// >>> verification/row_fabric.sv
// row interconnect model: other sources on row inputs, wire level of row outputs
`timescale 1ns/1ns
module row_fabric (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] row_out,
  input  wire logic [3:0] row_out_en,
  input  wire logic [3:0] pattern,
  output logic      [3:0] row_in,
  output logic      [3:0] row_level
);
  logic [3:0] level_nxt;
  // a row nobody drives has no keeper, so show the inverse of its last level
  always_comb begin
    level_nxt = (row_out_en & row_out) | (~row_out_en & ~row_level);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_level <= 4'h0;
    end else begin
      row_level <= level_nxt;
    end
  end
  assign row_in = pattern;
endmodule : row_fabric

// >>> verification/tb.sv
// self-checking bench for the output routing register bank
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic rd; logic [31:0] d; logic [31:0] m; logic e;} note_type;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, mo = 1'b0, so = 1'b0, uact = 1'b0, s24 = 1'b0, s48 = 1'b0;
  logic [10:0] ev = 11'h0;
  logic [3:0]  pat = 4'h0, rin, rout, ren, lvl;
  logic [15:0] srcs = 16'h0, rnd = 16'h000D;
  logic        tsel, bclk, irq;
  note_type    q[$];
  int          err_total = 0, num_checks = 0, cyc = 0;

  block_output_routing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_function_out(mo), .secondary_function_out(so),
    .uart_data_bits_active(uact), .function_events(ev), .row_in(rin), .clock_sources(srcs),
    .system_clock_24m(s24), .system_clock_48m(s48), .row_out(rout), .row_out_en(ren),
    .target_select(tsel), .block_clock(bclk), .interrupt_source(irq));
  row_fabric u_fab (.pclk(pclk), .presetn(presetn), .row_out(rout), .row_out_en(ren),
    .pattern(pat), .row_in(rin), .row_level(lvl));

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    s48 <= ~s48;
    if (s48) begin
      s24 <= ~s24;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [10:0] msk(input logic [3:0] f);
    case (f[2:0])
      3'h0: msk = 11'h01F;
      3'h1: msk = 11'h017;
      3'h2: msk = 11'h054;
      3'h5: msk = f[3] ? 11'h180 : 11'h200;
      3'h6: msk = 11'h180;
      3'h7: msk = 11'h410;
      default: msk = 11'h030;
    endcase
  endfunction : msk

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // one transfer; the answer is checked by the monitor from the note
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
                     input logic [31:0] m, input logic e);
    q.push_back('{!w, x, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: pready ends this wait, or else the bench timeout does
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      note_type nt;
      nt = q.pop_front();
      if (nt.rd) begin
        check("prdata", prdata & nt.m, nt.d & nt.m);
      end
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    logic [7:0] c;
    logic [3:0] f, em, es, dat;
    logic       tg, ts;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h10, 32'hFF, 32'h0, 32'h0, 1'b1);
    $display("test reset_and_map done");
    // every function and mode0, resync codes 00..10 with a held source
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      c = rnd[7:0];
      c[7:6] = 2'(i % 3); // source held level, never a raw system clock
      f = 4'(i);
      tg = f == 4'hE;
      if (tg) begin
        c[5] = i[4];
      end
      @(posedge pclk);
      mo <= rnd[8];
      so <= rnd[9];
      pat <= rnd[13:10];
      srcs <= {16{rnd[14]}};
      uact <= rnd[15];
      rnd = lfsr(rnd);
      ev <= rnd[10:0];
      apb(1'b1, 8'h08, {28'h0, rnd[15:12]}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 8'h04, {28'h0, f}, 32'h0, 32'h0, 1'b0); // block has no enable or data input here
      apb(1'b1, 8'h00, {24'h0, c}, 32'h0, 32'h0, 1'b0);
      repeat (10) @(posedge pclk);
      em = c[2] ? 4'h1 << c[1:0] : 4'h0;
      es = (c[5] && !tg) ? 4'h1 << c[4:3] : 4'h0;
      dat = (em & {4{mo}}) | (es & ~em & {4{so & (f[2:0] != 3'h5 || uact)}});
      ts = tg ? (c[5] ? c[3] : pat[c[4:3]]) : 1'b0;
      check("row_level", {28'h0, lvl & (em | es)}, {28'h0, dat});
      apb(1'b0, 8'h00, 32'h0, {24'h0, c}, 32'hFFFFFFFF, 1'b0);
      apb(1'b0, 8'h04, 32'h0, {28'h0, f}, 32'hFFFFFFFF, 1'b0);
      apb(1'b0, 8'h0C, 32'h0, {20'h0, em | es, dat, |(ev & msk(f)), srcs[0], ts, tg},
          32'hFFF, 1'b0);
    end
    $display("test routing_loop done");
    apb(1'b1, 8'h00, 32'hC0, 32'h0, 32'h0, 1'b0);
    repeat (8) @(posedge pclk);
    // the 24 MHz model toggles every second edge, so 40 edges give 20 moves
    tg = bclk;
    c = 8'h00;
    for (int k = 0; k < 40; k++) begin
      @(posedge pclk);
      c = c + 8'(bclk !== tg);
      tg = bclk;
    end
    check("direct_toggles", {24'h0, c}, 32'h14);
    $display("test direct_clock done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    check("reset_row_en", {28'h0, ren}, 32'h0);
    $display("test mid_reset done");
    repeat (2) @(posedge pclk);
    conclude();
  end
endmodule : tb
